// ===== bench/psc_ctl_model.sv
`timescale 1ns/1ns
module psc_ctl_model (
   // clock
   input wire logic clk,
   // address, selects, strobes
   output logic [psc_pkg::ADDR_W-1:0] addr,
   output logic sel_first_n,
   output logic sel_second,
   output logic sel_third_n,
   output logic proc_stb_n,
   output logic ctrl_stb_n,
   output logic step_n,
   // write controls
   output logic gw_n,
   output logic gate_n,
   output logic [psc_pkg::LANES-1:0] lane_n,
   // static and asynchronous pins
   output logic oe_n,
   output logic sleep_req,
   output logic strap,
   // shared data lines
   input wire logic [psc_pkg::DATA_W-1:0] dev_data,
   input wire logic dev_oe,
   output logic [psc_pkg::DATA_W-1:0] pin_data
);
   logic [psc_pkg::DATA_W-1:0] wdata = 36'h0;
   logic drive = 1'b0;
   logic [psc_pkg::DATA_W-1:0] float_reg = 36'h5A5A5A5A5;

   // released lines show a changing pattern, never the last value
   assign pin_data = dev_oe ? dev_data : (drive ? wdata : float_reg);
   always_ff @(posedge clk) begin
      float_reg <= ~pin_data;
   end

   // one bus cycle, changed just after the falling edge
   task automatic put(input logic ps, cs, st, gw, gt, input logic [psc_pkg::LANES-1:0] ln,
                      input logic [psc_pkg::ADDR_W-1:0] a,
                      input logic [psc_pkg::DATA_W-1:0] d, input logic dv);
      if ($time != 0) begin
         @(negedge clk);
      end
      proc_stb_n = ps;
      ctrl_stb_n = cs;
      step_n = st;
      gw_n = gw;
      gate_n = gt;
      lane_n = ln;
      addr = a;
      wdata = d;
      drive = dv;
   endtask

   task automatic sel(input logic f, s, t);
      sel_first_n = f;
      sel_second = s;
      sel_third_n = t;
   endtask

   task automatic pins(input logic o, z, m);
      oe_n = o;
      sleep_req = z;
      strap = m;
   endtask

   initial begin
      put(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 4'hF, 10'h000, 36'h0, 1'b0);
      sel(1'b0, 1'b1, 1'b0);
      pins(1'b1, 1'b0, 1'b1);
   end
endmodule

// ===== bench/testbench.sv
`timescale 1ns/1ns
module testbench;
   typedef logic [psc_pkg::DATA_W-1:0] psc_word_t;
   typedef logic [psc_pkg::ADDR_W-1:0] psc_addr_t;
   logic clock = 1'b0;
   logic srst = 1'b1;
   psc_addr_t addr;
   logic sf_n, s2, s3_n, ps_n, cs_n, st_n, gw_n, gt_n, oe_n, sleep_req, strap;
   logic dev_oe, selected, sleeping;
   logic [psc_pkg::LANES-1:0] lane_n;
   psc_word_t pin_data, dev_data;
   int miscompares = 0;
   int n_compared = 0;

   always #5 clock = ~clock;

   psc_top psc_top_inst (.CLOCK(clock), .SRST(srst), .CLOCK_EN(1'b1), .ADDRESS(addr),
      .SELECT_FIRST_N(sf_n), .SELECT_SECOND_HIGH(s2), .SELECT_THIRD_N(s3_n),
      .PROC_ADDR_STROBE_N(ps_n), .CTRL_ADDR_STROBE_N(cs_n), .BURST_STEP_N(st_n),
      .GLOBAL_WRITE_N(gw_n), .BYTE_WRITE_GATE_N(gt_n), .BYTE_LANE_SELECT_N(lane_n),
      .OUTPUT_DRIVE_N(oe_n), .SLEEP_REQUEST(sleep_req), .BURST_ORDER_STRAP(strap),
      .DATA_IN(pin_data), .DATA_OUT(dev_data), .DATA_OE(dev_oe), .SELECTED(selected),
      .SLEEPING(sleeping));

   psc_ctl_model psc_ctl_model_inst (.clk(clock), .addr(addr), .sel_first_n(sf_n),
      .sel_second(s2), .sel_third_n(s3_n), .proc_stb_n(ps_n), .ctrl_stb_n(cs_n),
      .step_n(st_n), .gw_n(gw_n), .gate_n(gt_n), .lane_n(lane_n), .oe_n(oe_n),
      .sleep_req(sleep_req), .strap(strap), .dev_data(dev_data), .dev_oe(dev_oe),
      .pin_data(pin_data));

   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic check(input psc_word_t seen, input psc_word_t exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish;
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic put(input logic ps, cs, st, gw, gt, input logic [3:0] ln,
                      input psc_addr_t a, input psc_word_t d, input logic dv);
      psc_ctl_model_inst.put(ps, cs, st, gw, gt, ln, a, d, dv);
   endtask

   task automatic idle(input int n);
      repeat (n) put(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 4'hF, 10'h000, 36'h0, 1'b0);
   endtask

   // strobe cycle, then write continuation cycles holding data and controls
   task automatic wr(input logic proc, input psc_addr_t a, input psc_word_t d,
                     input logic gw, gt, input logic [3:0] ln);
      put(!proc, proc, 1'b1, gw, gt, ln, a, d, 1'b1);
      repeat (3) put(1'b1, 1'b1, 1'b1, gw, gt, ln, a, d, 1'b1);
      check(psc_word_t'(dev_oe), psc_word_t'(gw && (gt || (&ln)) && !oe_n));
      idle(2);
   endtask

   task automatic rd(input logic [1:0] stb, input psc_addr_t a, input psc_word_t exp);
      put(stb[1], stb[0], 1'b1, 1'b1, 1'b1, 4'hF, a, 36'h0, 1'b0);
      idle(6);
      check(dev_data, exp);
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_reset_state;
      check(psc_word_t'({selected, dev_oe}), 36'h0);
   endtask

   task automatic t_write_read;
      psc_ctl_model_inst.pins(1'b0, 1'b0, 1'b1);
      wr(1'b0, 10'h010, 36'h123456789, 1'b0, 1'b1, 4'hF);
      rd(2'b10, 10'h010, 36'h123456789);
      wr(1'b1, 10'h011, 36'hABCDE0123, 1'b0, 1'b1, 4'hF);
      rd(2'b00, 10'h011, 36'hABCDE0123);
      check(psc_word_t'(dev_oe), 36'h1);
   endtask

   task automatic t_lane_write;
      wr(1'b0, 10'h010, 36'hFFFFFFFFF, 1'b1, 1'b0, 4'hD);
      wr(1'b0, 10'h010, 36'h000000000, 1'b1, 1'b1, 4'h0);
      rd(2'b10, 10'h010, 36'h12347FF89);
   endtask

   task automatic t_output_drive;
      psc_ctl_model_inst.pins(1'b1, 1'b0, 1'b1);
      rd(2'b10, 10'h011, 36'hABCDE0123);
      check(psc_word_t'(dev_oe), 36'h0);
      psc_ctl_model_inst.pins(1'b0, 1'b0, 1'b1);
      idle(5);
      check(psc_word_t'(dev_oe), 36'h1);
   endtask

   task automatic t_selects;
      logic [2:0] bad [3] = '{3'b110, 3'b000, 3'b011};
      rd(2'b10, 10'h010, 36'h12347FF89);
      psc_ctl_model_inst.sel(1'b1, 1'b1, 1'b0);
      put(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 4'hF, 10'h011, 36'h0, 1'b0);
      idle(5);
      check(psc_word_t'(selected), 36'h1);
      foreach (bad[i]) begin
         psc_ctl_model_inst.sel(bad[i][2], bad[i][1], bad[i][0]);
         // deselected: no read happens, the output keeps the last word
         rd(2'b10, 10'h011, 36'h12347FF89);
         check(psc_word_t'({selected, dev_oe}), 36'h0);
         psc_ctl_model_inst.sel(1'b0, 1'b1, 1'b0);
         rd(2'b10, 10'h010, 36'h12347FF89);
         check(psc_word_t'(selected), 36'h1);
      end
   endtask

   task automatic t_burst(input logic inter);
      psc_word_t seen [14];
      logic [1:0] off;
      int j;
      j = 0;
      for (int k = 0; k < 4; k++) begin
         wr(1'b0, psc_addr_t'(10'h020 + k), psc_word_t'({inter, 8'hA5, 2'(k)}), 1'b0,
            1'b1, 4'hF);
      end
      fork
         begin
            put(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 4'hF, 10'h021, 36'h0, 1'b0);
            put(1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 4'hF, 10'h3FF, 36'h0, 1'b0);
            psc_ctl_model_inst.sel(1'b1, 1'b0, 1'b1);
            repeat (2) put(1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 4'hF, 10'h3FF, 36'h0, 1'b0);
            idle(9);
            psc_ctl_model_inst.sel(1'b0, 1'b1, 1'b0);
         end
         begin
            for (int i = 0; i < 14; i++) begin
               @(posedge clock);
               #2 seen[i] = dev_data;
            end
         end
      join
      for (int i = 10; i >= 0; i--) begin
         if (seen[i] === psc_word_t'({inter, 8'hA5, 2'h1})) begin
            j = i;
         end
      end
      for (int k = 0; k < 4; k++) begin
         off = inter ? (2'h1 ^ 2'(k)) : 2'(2'h1 + 2'(k));
         check(seen[j + k], psc_word_t'({inter, 8'hA5, off}));
      end
   endtask

   task automatic t_sleep;
      psc_ctl_model_inst.pins(1'b0, 1'b1, 1'b1);
      idle(5);
      check(psc_word_t'(sleeping), 36'h1);
      psc_ctl_model_inst.pins(1'b0, 1'b0, 1'b1);
      idle(5);
      check(psc_word_t'(sleeping), 36'h0);
      rd(2'b10, 10'h011, 36'hABCDE0123);
   endtask

   task automatic t_linear_order;
      psc_ctl_model_inst.pins(1'b0, 1'b0, 1'b0);
      srst = 1'b1;
      idle(8);
      srst = 1'b0;
      idle(1);
      t_reset_state;
      t_burst(1'b0);
   endtask

   // ------------------------------------------------------------
   // main sequence and watchdog
   // ------------------------------------------------------------
   initial begin
      repeat (8) @(negedge clock);
      srst = 1'b0;
      t_reset_state;
      t_write_read;
      t_lane_write;
      t_output_drive;
      t_selects;
      t_burst(1'b1);
      t_sleep;
      t_linear_order;
      tally_and_finish;
   end

   initial begin
      #200000;
      miscompares++;
      tally_and_finish;
   end
endmodule

// ===== hw/psc_buf.sv
`timescale 1ns/1ns
module psc_buf #(
   parameter int W = 36
) (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   input wire logic ce,
   // both sides
   psc_rd_if.buf_side io
);
   logic [W-1:0] slot_reg [2];
   logic [1:0] count_reg;
   logic wr_ptr_reg;
   logic rd_ptr_reg;
   logic push;
   logic pop;

   assign io.in_ready = (count_reg != 2'h2);
   assign io.out_valid = (count_reg != 2'h0);
   assign io.out_data = slot_reg[rd_ptr_reg];
   assign push = io.in_valid && io.in_ready;
   assign pop = io.out_valid && io.out_ready;

   always_ff @(posedge clk) begin
      if (srst) begin
         count_reg <= 2'h0;
         wr_ptr_reg <= 1'b0;
         rd_ptr_reg <= 1'b0;
      end else if (ce) begin
         if (push) begin
            slot_reg[wr_ptr_reg] <= io.in_data;
            wr_ptr_reg <= ~wr_ptr_reg;
         end
         if (pop) begin
            rd_ptr_reg <= ~rd_ptr_reg;
         end
         count_reg <= 2'(count_reg + {1'b0, push} - {1'b0, pop});
      end
   end
endmodule

// ===== hw/psc_mem.sv
`timescale 1ns/1ns
module psc_mem #(
   parameter int AW = 10,
   parameter int LN = 4,
   parameter int LW = 9
) (
   // clock
   input wire logic clk,
   input wire logic ce,
   // write port
   input wire logic we,
   input wire logic [LN-1:0] lane_we,
   input wire logic [AW-1:0] waddr,
   input wire logic [LN*LW-1:0] wdata,
   // read port, data out of a register
   input wire logic [AW-1:0] raddr,
   output logic [LN*LW-1:0] rdata
);
   logic [LN*LW-1:0] cells [2**AW];

   always_ff @(posedge clk) begin
      if (ce && we) begin
         for (int i = 0; i < LN; i++) begin
            if (lane_we[i]) begin
               cells[waddr][i*LW +: LW] <= wdata[i*LW +: LW];
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (ce) begin
         rdata <= cells[raddr];
      end
   end
endmodule

// ===== hw/psc_pkg.sv
package psc_pkg;
   // ------------------------------------------------------------
   // geometry
   // ------------------------------------------------------------
   localparam int ADDR_W = 10;
   localparam int LANES = 4;
   localparam int LANE_W = 9;
   localparam int DATA_W = LANES * LANE_W;
   localparam int LOW_BITS = 2;
   // ------------------------------------------------------------
   // reset values and counts
   // ------------------------------------------------------------
   localparam logic [1:0] BURST_RST = 2'h0;
   localparam logic [1:0] STEP_ONE = 2'h1;
   localparam int BUF_DEPTH = 2;
   localparam int STRAP_SYNC_STAGES = 2;

   typedef enum logic [1:0] {
      PSC_DESEL = 2'b00,
      PSC_READ = 2'b01,
      PSC_WRITE = 2'b10,
      PSC_PWRITE = 2'b11
   } psc_state_t;

   // next burst offset for linear or interleaved order
   function automatic logic [1:0] psc_burst_addr(input logic [1:0] start,
                                                  input logic [1:0] step,
                                                  input logic interleave);
      if (interleave) begin
         return start ^ step;
      end
      return 2'(start + step);
   endfunction
endpackage

// ===== hw/psc_rd_if.sv
`timescale 1ns/1ns
interface psc_rd_if #(parameter int W = 36);
   logic in_valid;
   logic in_ready;
   logic [W-1:0] in_data;
   logic out_valid;
   logic out_ready;
   logic [W-1:0] out_data;
   modport src (output in_valid, in_data, input in_ready);
   modport buf_side (input in_valid, in_data, output in_ready,
                     output out_valid, out_data, input out_ready);
   modport dst (input out_valid, out_data, output out_ready);
endinterface

// ===== hw/psc_top.sv
// What this block does
// - every synchronous input is acted on only at the rising clock edge.
// - the burst counter steps on the edge after burst step is sampled low.
// - first select is active low and joins the others to select the device.
// - second select is active high; selection needs it high, others low.
// - third select is active low and joins the others in selection.
// - selects are looked at only when a new address is loaded.
// - processor strobe is ignored while first select is high.
// - output enable low drives data pins, high releases them as inputs.
// - first read cycle after deselect keeps data pins released.
// - a sampled low burst step moves to the next burst address.
// - a low strobe captures the address and loads the low bits to the counter.
// - controller strobe, sampled low, starts a new access with address capture.
// - with both strobes low and first select low only the processor strobe counts.
// - sleep high holds the device quiet and keeps memory contents.
// - sleep defaults low; the far party keeps it low for normal work.
// - write data is captured into a data register at the rising edge.
// - read data belongs to the address sampled four edges earlier after a controller strobe, five after a processor strobe.
// - output enable high keeps all data and parity lines released.
// - order strap low selects linear order, high selects interleaved.
// - global write low writes every lane, overriding lane selects and gate.
// - address is sampled only with a strobe low and all selects active.
// - any detected write cycle releases the data lines regardless of enable.
`timescale 1ns/1ns
module psc_top #(
   parameter int ADDR_W = psc_pkg::ADDR_W,
   parameter int LANES = psc_pkg::LANES,
   parameter int LANE_W = psc_pkg::LANE_W
) (
   // clock, reset, enable
   input wire logic CLOCK,
   input wire logic SRST,
   input wire logic CLOCK_EN,
   // address and selects
   input wire logic [ADDR_W-1:0] ADDRESS,
   input wire logic SELECT_FIRST_N,
   input wire logic SELECT_SECOND_HIGH,
   input wire logic SELECT_THIRD_N,
   // strobes and burst
   input wire logic PROC_ADDR_STROBE_N,
   input wire logic CTRL_ADDR_STROBE_N,
   input wire logic BURST_STEP_N,
   // writes
   input wire logic GLOBAL_WRITE_N,
   input wire logic BYTE_WRITE_GATE_N,
   input wire logic [LANES-1:0] BYTE_LANE_SELECT_N,
   // pin-side controls from outside the clock domain
   input wire logic OUTPUT_DRIVE_N,
   input wire logic SLEEP_REQUEST,
   input wire logic BURST_ORDER_STRAP,
   // data and parity lines
   input wire logic [LANES*LANE_W-1:0] DATA_IN,
   output logic [LANES*LANE_W-1:0] DATA_OUT,
   output logic DATA_OE,
   // status
   output logic SELECTED,
   output logic SLEEPING
);
   localparam int DW = LANES * LANE_W;

   // ------------------------------------------------------------
   // two-stage synchronisers for off-domain inputs
   // ------------------------------------------------------------
   logic oe_n_s1_reg, oe_n_s2_reg;
   logic sleep_s1_reg, sleep_s2_reg;
   logic strap_s1_reg, strap_s2_reg;

   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         oe_n_s1_reg <= 1'b1;
         oe_n_s2_reg <= 1'b1;
         sleep_s1_reg <= 1'b0;
         sleep_s2_reg <= 1'b0;
      end else if (CLOCK_EN) begin
         oe_n_s1_reg <= OUTPUT_DRIVE_N;
         oe_n_s2_reg <= oe_n_s1_reg;
         sleep_s1_reg <= SLEEP_REQUEST;
         sleep_s2_reg <= sleep_s1_reg;
      end
   end

   // strap stages run through reset so the pin level is ready to be caught
   always_ff @(posedge CLOCK) begin
      if (CLOCK_EN) begin
         strap_s1_reg <= BURST_ORDER_STRAP;
         strap_s2_reg <= strap_s1_reg;
      end
   end

   // ------------------------------------------------------------
   // input registers
   // ------------------------------------------------------------
   logic run;
   logic [ADDR_W-1:0] addr_in_reg;
   logic sel1_n_reg, sel2_reg, sel3_n_reg;
   logic pstb_n_reg, cstb_n_reg, step_n_reg;
   logic gw_n_reg, bwe_n_reg;
   logic [LANES-1:0] bws_n_reg;
   logic [DW-1:0] din_reg;
   logic order_reg;

   // sleep freezes the access path; memory keeps its contents
   assign run = CLOCK_EN && !sleep_s2_reg;

   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         pstb_n_reg <= 1'b1;
         cstb_n_reg <= 1'b1;
         step_n_reg <= 1'b1;
         gw_n_reg <= 1'b1;
         bwe_n_reg <= 1'b1;
         bws_n_reg <= '1;
         sel1_n_reg <= 1'b1;
         sel2_reg <= 1'b0;
         sel3_n_reg <= 1'b1;
      end else if (run) begin
         pstb_n_reg <= PROC_ADDR_STROBE_N;
         cstb_n_reg <= CTRL_ADDR_STROBE_N;
         step_n_reg <= BURST_STEP_N;
         gw_n_reg <= GLOBAL_WRITE_N;
         bwe_n_reg <= BYTE_WRITE_GATE_N;
         bws_n_reg <= BYTE_LANE_SELECT_N;
         sel1_n_reg <= SELECT_FIRST_N;
         sel2_reg <= SELECT_SECOND_HIGH;
         sel3_n_reg <= SELECT_THIRD_N;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (run) begin
         addr_in_reg <= ADDRESS;
         din_reg <= DATA_IN;
      end
   end

   // strap is caught while reset is high and held after release
   always_ff @(posedge CLOCK) begin
      if (CLOCK_EN && SRST) begin
         order_reg <= strap_s2_reg;
      end
   end

   // ------------------------------------------------------------
   // access decode
   // ------------------------------------------------------------
   logic p_start, c_start, new_addr, sel_ok, wr_lanes_any;
   logic [LANES-1:0] lane_mask;

   assign sel_ok = !sel1_n_reg && sel2_reg && !sel3_n_reg;
   assign p_start = !pstb_n_reg && !sel1_n_reg;
   assign c_start = !cstb_n_reg && !p_start;
   assign new_addr = p_start || c_start;

   always_comb begin
      if (!gw_n_reg) begin
         lane_mask = '1;
      end else if (!bwe_n_reg) begin
         lane_mask = ~bws_n_reg;
      end else begin
         lane_mask = '0;
      end
   end
   assign wr_lanes_any = (lane_mask != '0);

   // ------------------------------------------------------------
   // control state and burst counter
   // ------------------------------------------------------------
   psc_pkg::psc_state_t state_reg;
   logic [ADDR_W-1:0] base_reg;
   logic [1:0] start_reg, step_reg;
   logic [ADDR_W-1:0] cur_addr;
   logic first_read_reg;
   logic was_desel_reg;

   assign cur_addr = {base_reg[ADDR_W-1:2],
                      psc_pkg::psc_burst_addr(start_reg, step_reg, order_reg)};

   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         state_reg <= psc_pkg::PSC_DESEL;
         base_reg <= '0;
         start_reg <= psc_pkg::BURST_RST;
         step_reg <= psc_pkg::BURST_RST;
         first_read_reg <= 1'b0;
         was_desel_reg <= 1'b1;
      end else if (run) begin
         first_read_reg <= 1'b0;
         if (new_addr) begin
            if (sel_ok) begin
               base_reg <= addr_in_reg;
               start_reg <= addr_in_reg[1:0];
               step_reg <= psc_pkg::BURST_RST;
               first_read_reg <= was_desel_reg;
               was_desel_reg <= 1'b0;
               if (p_start) begin
                  state_reg <= psc_pkg::PSC_PWRITE;
               end else if (wr_lanes_any) begin
                  state_reg <= psc_pkg::PSC_WRITE;
               end else begin
                  state_reg <= psc_pkg::PSC_READ;
               end
            end else begin
               state_reg <= psc_pkg::PSC_DESEL;
               was_desel_reg <= 1'b1;
            end
         end else begin
            case (state_reg)
               psc_pkg::PSC_DESEL: begin
                  state_reg <= psc_pkg::PSC_DESEL;
               end
               psc_pkg::PSC_PWRITE, psc_pkg::PSC_READ, psc_pkg::PSC_WRITE: begin
                  // burst continuation: writes decide per cycle
                  state_reg <= wr_lanes_any ? psc_pkg::PSC_WRITE : psc_pkg::PSC_READ;
                  if (!step_n_reg) begin
                     step_reg <= 2'(step_reg + psc_pkg::STEP_ONE);
                  end
               end
               default: begin
                  state_reg <= psc_pkg::PSC_DESEL;
               end
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // array, read pipe and write path
   // ------------------------------------------------------------
   logic mem_we;
   logic [DW-1:0] mem_rdata;
   logic [ADDR_W-1:0] rd_addr;

   // processor-started cycles write on the following edge
   assign mem_we = (state_reg == psc_pkg::PSC_WRITE) && wr_lanes_any && !new_addr;
   assign rd_addr = cur_addr;

   psc_mem #(.AW(ADDR_W), .LN(LANES), .LW(LANE_W)) u_mem (
      .clk(CLOCK),
      .ce(run),
      .we(mem_we),
      .lane_we(lane_mask),
      .waddr(cur_addr),
      .wdata(din_reg),
      .raddr(rd_addr),
      .rdata(mem_rdata)
   );

   logic rd_valid_reg;
   psc_rd_if #(.W(DW)) rd_if ();

   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         rd_valid_reg <= 1'b0;
      end else if (run) begin
         rd_valid_reg <= (state_reg == psc_pkg::PSC_READ) && !new_addr;
      end
   end

   assign rd_if.in_valid = rd_valid_reg && run;
   assign rd_if.in_data = mem_rdata;
   assign rd_if.out_ready = run;

   psc_buf #(.W(DW)) u_buf (
      .clk(CLOCK),
      .srst(SRST),
      .ce(CLOCK_EN),
      .io(rd_if.buf_side)
   );

   // ------------------------------------------------------------
   // pin drivers
   // ------------------------------------------------------------
   logic drive;
   assign drive = !oe_n_s2_reg
                  && (state_reg == psc_pkg::PSC_READ)
                  && !first_read_reg
                  && !wr_lanes_any;

   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         DATA_OUT <= '0;
         DATA_OE <= 1'b0;
         SELECTED <= 1'b0;
         SLEEPING <= 1'b0;
      end else if (CLOCK_EN) begin
         if (rd_if.out_valid) begin
            DATA_OUT <= rd_if.out_data;
         end
         DATA_OE <= drive && !sleep_s2_reg;
         SELECTED <= (state_reg != psc_pkg::PSC_DESEL);
         SLEEPING <= sleep_s2_reg;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   property p_oe_off_high;
      @(posedge CLOCK) disable iff (SRST) (CLOCK_EN && oe_n_s2_reg) |=> !DATA_OE;
   endproperty
   a_oe_off_high: assert property (p_oe_off_high) else $error("data driven with enable high");

   property p_write_quiet;
      @(posedge CLOCK) disable iff (SRST) (CLOCK_EN && wr_lanes_any) |=> !DATA_OE;
   endproperty
   a_write_quiet: assert property (p_write_quiet) else $error("data driven in write");

   property p_first_read;
      @(posedge CLOCK) disable iff (SRST) (CLOCK_EN && first_read_reg) |=> !DATA_OE;
   endproperty
   a_first_read: assert property (p_first_read) else $error("first read not quiet");

   property p_step;
      @(posedge CLOCK) disable iff (SRST)
         (run && !new_addr && !step_n_reg && state_reg != psc_pkg::PSC_DESEL)
         |=> step_reg == 2'($past(step_reg) + 2'h1);
   endproperty
   a_step: assert property (p_step) else $error("burst did not step");

   property p_capture;
      @(posedge CLOCK) disable iff (SRST)
         (run && new_addr && sel_ok) |=> (base_reg == $past(addr_in_reg)) && step_reg == 2'h0;
   endproperty
   a_capture: assert property (p_capture) else $error("address not captured");

   property p_desel;
      @(posedge CLOCK) disable iff (SRST)
         (run && new_addr && !sel_ok) |=> state_reg == psc_pkg::PSC_DESEL;
   endproperty
   a_desel: assert property (p_desel) else $error("not deselected");

   property p_pstb_ignored;
      @(posedge CLOCK) disable iff (SRST)
         (run && !pstb_n_reg && sel1_n_reg && cstb_n_reg)
         |=> state_reg != psc_pkg::PSC_PWRITE;
   endproperty
   a_pstb_ignored: assert property (p_pstb_ignored) else $error("strobe not ignored");

   property p_sleep_hold;
      @(posedge CLOCK) disable iff (SRST) (CLOCK_EN && sleep_s2_reg) |=> $stable(state_reg);
   endproperty
   a_sleep_hold: assert property (p_sleep_hold) else $error("state moved in sleep");
endmodule
